//--- common/fault_supervisor_pkg.sv
package fault_supervisor_pkg;

  // Register offsets (byte addresses).
  localparam logic [7:0] CTRL_OFS        = 8'h00;
  localparam logic [7:0] STATUS_OFS      = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS    = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS    = 8'h0C;
  localparam logic [7:0] FAULT_MONITOR_SETTING_MASK_OFS   = 8'h10;
  localparam logic [7:0] FAULT_MONITOR_SETTING_ERRBIT_OFS = 8'h14;
  localparam logic [7:0] SYNC_WIN_OFS    = 8'h18;
  localparam logic [7:0] LOG_QUERY_OFS   = 8'h1C;
  localparam logic [7:0] NODE_ID_OFS     = 8'h20;
  localparam logic [7:0] POSITION_OFS    = 8'h24;
  localparam logic [7:0] SYNC_DEV_OFS    = 8'h28;

  // Control and error-bit register fields.
  localparam int MON_LSB     = 0;
  localparam int HALT_BIT    = 4;
  localparam int COUNT_LSB   = 8;
  localparam int ERRBIT_LSB  = 0;
  localparam int ERRBIT_EN   = 8;

  // Interrupt status bits.
  localparam int IRQ_SHUTDOWN  = 0;
  localparam int IRQ_AXIS_ERR  = 1;
  localparam int IRQ_SYNC_ERR  = 2;
  localparam int IRQ_LINK_TRY  = 3;
  localparam int IRQ_WR_REJECT = 4;
  localparam int IRQ_W         = 5;

  // Reset values.
  localparam logic [1:0]  MON_RST    = 2'h1;
  localparam logic        HALT_RST   = 1'b0;
  localparam logic [2:0]  COUNT_RST  = 3'h2;
  localparam logic [31:0] MASK_RST   = 32'h0000_0000;
  localparam logic [31:0] WINDOW_RST = 32'h0000_03E8;

  // Log layout.
  localparam int          LOG_DEPTH   = 10;
  localparam logic [23:0] LOG_EMPTY   = 24'h2D2D2D;
  localparam logic [3:0]  CAUSE_AXIS  = 4'h1;
  localparam logic [3:0]  CAUSE_FAULT_MONITOR_SETTING  = 4'h2;
  localparam logic [3:0]  CAUSE_SYNC  = 4'h3;
  localparam logic [3:0]  CAUSE_LINK  = 4'h4;
  localparam logic [3:0]  CAUSE_OPER  = 4'h5;
  localparam logic [2:0]  AXIS_MIN    = 3'h1;
  localparam logic [2:0]  AXIS_MAX    = 3'h4;

  // Timing.
  localparam int CLK_MHZ      = 250;
  localparam int POLL_MS      = 10;
  localparam int POLL_CYCLES  = POLL_MS * 1000 * CLK_MHZ;

  // Monitoring settings.
  typedef enum logic [1:0] {
    MON_OFF  = 2'h0,
    MON_ON   = 2'h1,
    MON_AUTO = 2'h2
  } fault_monitor_setting_e;

  // Software configuration carried as one bundle.
  typedef struct packed {
    logic [1:0]  fault_monitor_setting;
    logic        sync_fault_halt;
    logic [2:0]  axis_module_count;
    logic        errbit_en;
    logic [4:0]  sensor_error_bit_select;
    logic [31:0] sensor_bit_suppress_mask;
    logic [31:0] sync_deviation_window;
  } cfg_s;

endpackage

//--- logic/axis_fault_supervisor.sv
`timescale 1ns/1ps
module axis_fault_supervisor
  import fault_supervisor_pkg::*;
#(
  parameter int POLL_COUNT = POLL_CYCLES
) (
  // Clock and reset.
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST,
  // Register port.
  input  wire logic [7:0]  i_ADDR,
  input  wire logic [31:0] i_WDATA,
  input  wire logic        i_WR,
  input  wire logic        i_RD,
  output logic      [31:0] o_RDATA,
  // Operator and switch inputs.
  input  wire logic        i_ENABLE,
  input  wire logic [3:0]  i_NODE_ID,
  // Axis module status as received over the field bus.
  input  wire logic [3:0]  i_AXIS_ERR,
  input  wire logic [3:0]  i_AXIS_STANDBY,
  input  wire logic [3:0]  i_AXIS_FAULT_MONITOR_SETTING_ON,
  input  wire logic        i_LINK_OK,
  // Process inputs.
  input  wire logic [31:0] i_SENSOR_WORD,
  input  wire logic [31:0] i_SYNC_DEV,
  // Outputs to axes and system.
  output logic      [3:0]  o_AXIS_ENABLE,
  output logic             o_READY,
  output logic             o_LINK_RETRY,
  output logic             o_SENSOR_ERR,
  output logic      [31:0] o_POSITION,
  output logic             o_IRQ
);

  typedef enum logic [1:0] {
    ST_RUN,
    ST_FAULT,
    ST_WAIT_ACK,
    ST_WAIT_REEN
  } sup_state_e;

  // Wraps an index into the ten log slots.
  function automatic logic [3:0] wrap10(input logic [4:0] v);
    logic [4:0] r;
    r = (v >= 5'(LOG_DEPTH)) ? v - 5'(LOG_DEPTH) : v;
    return r[3:0];
  endfunction

  // Magnitude of a signed deviation.
  function automatic logic [31:0] magnitude(input logic [31:0] v);
    return v[31] ? (~v + 32'h0000_0001) : v;
  endfunction

  cfg_s                 cfg_reg;
  logic [IRQ_W-1:0]     irq_stat_reg;
  logic [IRQ_W-1:0]     irq_mask_reg;
  logic [IRQ_W-1:0]     irq_event;
  sup_state_e           state_reg;
  logic [31:0]          poll_cnt_reg;
  logic                 poll_tick;
  logic                 enable_d_reg;
  logic                 enable_rise;
  logic [3:0]           active_axes;
  logic [3:0]           axis_fault;
  logic                 fault_monitor_setting_err;
  logic                 sync_err;
  logic                 any_err;
  logic                 need_ack_reg;
  logic                 need_ack_next;
  logic [7:0]           cause_reg;
  logic [7:0]           cause_next;
  logic [7:0]           log_mem [LOG_DEPTH];
  logic [3:0]           log_wr_reg;
  logic [3:0]           log_cnt_reg;
  logic [3:0]           line_reg;
  logic                 shutdown;
  logic                 ready_next;
  logic [31:0]          errbit_vec;
  logic [31:0]          log_line;
  logic [3:0]           log_slot;
  logic                 wr_cfg_ro;

  // Axes 1..count are present; counts outside 1..4 are clamped.
  always_comb begin
    logic [2:0] n;
    n = cfg_reg.axis_module_count;
    if (n < AXIS_MIN) begin
      n = AXIS_MIN;
    end else if (n > AXIS_MAX) begin
      n = AXIS_MAX;
    end
    active_axes = 4'((5'h01 << n) - 5'h01);
  end

  // Sensor bit handling: one error bit plus a free suppression mask.
  assign errbit_vec = cfg_reg.errbit_en ? (32'h0000_0001 << cfg_reg.sensor_error_bit_select) : 32'h0000_0000;
  assign fault_monitor_setting_err   = |(i_SENSOR_WORD & errbit_vec);

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      o_POSITION   <= 32'h0000_0000;
      o_SENSOR_ERR <= 1'b0;
    end else begin
      o_POSITION   <= i_SENSOR_WORD & ~cfg_reg.sensor_bit_suppress_mask & ~errbit_vec;
      o_SENSOR_ERR <= fault_monitor_setting_err;
    end
  end

  // Axis and sync error evaluation. Off mode masks every axis error.
  assign axis_fault = (cfg_reg.fault_monitor_setting == MON_OFF) ? 4'h0 : (i_AXIS_ERR & active_axes);
  assign sync_err   = cfg_reg.sync_fault_halt &&
                      (magnitude(i_SYNC_DEV) > cfg_reg.sync_deviation_window);
  assign any_err    = (|axis_fault) || sync_err;

  // Shared 10 ms tick for link retries and automatic acknowledge.
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      poll_cnt_reg <= 32'h0000_0000;
    end else if (poll_cnt_reg >= 32'(POLL_COUNT - 1)) begin
      poll_cnt_reg <= 32'h0000_0000;
    end else begin
      poll_cnt_reg <= poll_cnt_reg + 32'h0000_0001;
    end
  end
  assign poll_tick = (poll_cnt_reg >= 32'(POLL_COUNT - 1));

  // Link retry pulse while monitoring is off and the link is down.
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      o_LINK_RETRY <= 1'b0;
    end else begin
      o_LINK_RETRY <= poll_tick && !i_LINK_OK && (cfg_reg.fault_monitor_setting == MON_OFF);
    end
  end

  // Enable edge detect for acknowledge and restart.
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      enable_d_reg <= 1'b0;
    end else begin
      enable_d_reg <= i_ENABLE;
    end
  end
  assign enable_rise = i_ENABLE && !enable_d_reg;

  // Acknowledge is owed only when a faulting axis runs its own monitoring on.
  always_comb begin
    need_ack_next = need_ack_reg;
    if (state_reg == ST_RUN) begin
      need_ack_next = 1'b0;
    end
    if (cfg_reg.fault_monitor_setting == MON_ON && |(axis_fault & i_AXIS_FAULT_MONITOR_SETTING_ON)) begin
      need_ack_next = 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      need_ack_reg <= 1'b0;
    end else begin
      need_ack_reg <= need_ack_next;
    end
  end

  // Fault latch. Standby axes hold ready low outside off mode but leave the state in run.
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      state_reg <= ST_RUN;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          if (any_err) begin
            state_reg <= ST_FAULT;
          end
        end
        ST_FAULT: begin
          if (!any_err) begin
            if (cfg_reg.fault_monitor_setting == MON_AUTO) begin
              if (poll_tick) begin
                state_reg <= ST_RUN;
              end
            end else if (need_ack_reg) begin
              state_reg <= ST_WAIT_ACK;
            end else begin
              state_reg <= ST_RUN;
            end
          end
        end
        ST_WAIT_ACK: begin
          if (any_err) begin
            state_reg <= ST_FAULT;
          end else if (enable_rise) begin
            state_reg <= ST_WAIT_REEN;
          end
        end
        ST_WAIT_REEN: begin
          if (any_err) begin
            state_reg <= ST_FAULT;
          end else if (enable_rise) begin
            state_reg <= ST_RUN;
          end
        end
      endcase
    end
  end

  // Ready and axis enables; all axes drop together on any latched fault.
  assign ready_next = i_ENABLE && (state_reg == ST_RUN) && !any_err &&
                      !(|(i_AXIS_STANDBY & active_axes) && cfg_reg.fault_monitor_setting != MON_OFF);

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      o_READY       <= 1'b0;
      o_AXIS_ENABLE <= 4'h0;
    end else begin
      o_READY       <= ready_next;
      o_AXIS_ENABLE <= ready_next ? active_axes : 4'h0;
    end
  end

  // Cause code: type in the high nibble, lowest faulting axis in the low.
  always_comb begin
    cause_next = {CAUSE_OPER, 4'h0};
    if (sync_err) begin
      cause_next = {CAUSE_SYNC, 4'h0};
    end else if (|axis_fault) begin
      cause_next = {CAUSE_AXIS, axis_fault[0] ? 4'h1 : axis_fault[1] ? 4'h2 : axis_fault[2] ? 4'h3 : 4'h4};
    end else if (fault_monitor_setting_err) begin
      cause_next = {CAUSE_FAULT_MONITOR_SETTING, 4'h0};
    end else if (!i_LINK_OK) begin
      cause_next = {CAUSE_LINK, 4'h0};
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      cause_reg <= 8'h00;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // Shutdown is a falling ready while enable is still applied.
  assign shutdown = o_READY && !ready_next && i_ENABLE;

  // Circular log; slots never filled are masked by the count, not cleared.
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      log_wr_reg  <= 4'h0;
      log_cnt_reg <= 4'h0;
    end else if (shutdown) begin
      log_wr_reg <= wrap10({1'b0, log_wr_reg} + 5'h01);
      if (log_cnt_reg < 4'(LOG_DEPTH)) begin
        log_cnt_reg <= log_cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (shutdown) begin
      log_mem[log_wr_reg] <= cause_next;
    end
  end

  // Line i maps to slot wr-(10-i); empty lines sit at the top.
  assign log_slot = wrap10({1'b0, log_wr_reg} + {1'b0, line_reg});
  assign log_line = (line_reg < 4'(LOG_DEPTH) - log_cnt_reg) ?
                    {8'h00, LOG_EMPTY} : {24'h00_0000, log_mem[log_slot]};

  // Query line pointer: a write restarts at the oldest, each read steps on.
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      line_reg <= 4'h0;
    end else if (i_WR && i_ADDR == LOG_QUERY_OFS) begin
      line_reg <= 4'h0;
    end else if (i_RD && i_ADDR == LOG_QUERY_OFS) begin
      line_reg <= (line_reg == 4'(LOG_DEPTH - 1)) ? 4'h0 : line_reg + 4'h1;
    end
  end

  // Configuration writes.
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      cfg_reg.fault_monitor_setting    <= MON_RST;
      cfg_reg.sync_fault_halt          <= HALT_RST;
      cfg_reg.axis_module_count        <= COUNT_RST;
      cfg_reg.errbit_en                <= 1'b0;
      cfg_reg.sensor_error_bit_select  <= 5'h00;
      cfg_reg.sensor_bit_suppress_mask <= MASK_RST;
      cfg_reg.sync_deviation_window    <= WINDOW_RST;
    end else if (i_WR) begin
      unique case (i_ADDR)
        CTRL_OFS: begin
          // An illegal monitoring code is ignored rather than stored.
          if (i_WDATA[MON_LSB+:2] != 2'h3) begin
            cfg_reg.fault_monitor_setting <= i_WDATA[MON_LSB+:2];
          end
          cfg_reg.sync_fault_halt   <= i_WDATA[HALT_BIT];
          cfg_reg.axis_module_count <= i_WDATA[COUNT_LSB+:3];
        end
        FAULT_MONITOR_SETTING_ERRBIT_OFS: begin
          cfg_reg.sensor_error_bit_select <= i_WDATA[ERRBIT_LSB+:5];
          cfg_reg.errbit_en               <= i_WDATA[ERRBIT_EN];
        end
        FAULT_MONITOR_SETTING_MASK_OFS: cfg_reg.sensor_bit_suppress_mask <= i_WDATA;
        SYNC_WIN_OFS:  cfg_reg.sync_deviation_window    <= i_WDATA;
        default: ;
      endcase
    end
  end

  // Writes aimed at read-only process or status words are refused.
  assign wr_cfg_ro = i_WR && (i_ADDR == POSITION_OFS || i_ADDR == SYNC_DEV_OFS ||
                              i_ADDR == STATUS_OFS || i_ADDR == NODE_ID_OFS);

  // Interrupt events.
  always_comb begin
    irq_event                = '0;
    irq_event[IRQ_SHUTDOWN]  = shutdown;
    irq_event[IRQ_AXIS_ERR]  = (state_reg == ST_RUN) && (|axis_fault);
    irq_event[IRQ_SYNC_ERR]  = (state_reg == ST_RUN) && sync_err;
    irq_event[IRQ_LINK_TRY]  = poll_tick && !i_LINK_OK && (cfg_reg.fault_monitor_setting == MON_OFF);
    irq_event[IRQ_WR_REJECT] = wr_cfg_ro;
  end

  // Sticky status, write one to clear; a new event beats the clear.
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      irq_stat_reg <= '0;
    end else if (i_WR && i_ADDR == IRQ_STAT_OFS) begin
      irq_stat_reg <= (irq_stat_reg & ~i_WDATA[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      irq_mask_reg <= '0;
    end else if (i_WR && i_ADDR == IRQ_MASK_OFS) begin
      irq_mask_reg <= i_WDATA[IRQ_W-1:0];
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      o_IRQ <= 1'b0;
    end else begin
      o_IRQ <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read data in the cycle after the strobe; unmapped words read zero.
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      o_RDATA <= 32'h0000_0000;
    end else if (i_RD) begin
      unique case (i_ADDR)
        CTRL_OFS:        o_RDATA <= {21'h00_0000, cfg_reg.axis_module_count, 3'h0,
                                     cfg_reg.sync_fault_halt, 2'h0, cfg_reg.fault_monitor_setting};
        STATUS_OFS:      o_RDATA <= {12'h000, log_cnt_reg, 4'h0, o_AXIS_ENABLE, 2'h0, state_reg,
                                     i_LINK_OK, o_SENSOR_ERR, need_ack_reg, o_READY};
        IRQ_STAT_OFS:    o_RDATA <= {27'h000_0000, irq_stat_reg};
        IRQ_MASK_OFS:    o_RDATA <= {27'h000_0000, irq_mask_reg};
        FAULT_MONITOR_SETTING_MASK_OFS:   o_RDATA <= cfg_reg.sensor_bit_suppress_mask;
        FAULT_MONITOR_SETTING_ERRBIT_OFS: o_RDATA <= {23'h00_0000, cfg_reg.errbit_en, 3'h0, cfg_reg.sensor_error_bit_select};
        SYNC_WIN_OFS:    o_RDATA <= cfg_reg.sync_deviation_window;
        LOG_QUERY_OFS:   o_RDATA <= log_line;
        NODE_ID_OFS:     o_RDATA <= {28'h000_0000, i_NODE_ID};
        POSITION_OFS:    o_RDATA <= o_POSITION;
        SYNC_DEV_OFS:    o_RDATA <= i_SYNC_DEV;
        default:         o_RDATA <= 32'h0000_0000;
      endcase
    end else begin
      o_RDATA <= 32'h0000_0000;
    end
  end

endmodule // axis_fault_supervisor

//--- sim/axis_fault_supervisor_monitor.sv
`timescale 1ns/1ps
module axis_fault_supervisor_monitor
  import fault_supervisor_pkg::*;
#(
  parameter int POLL_COUNT = POLL_CYCLES
) (
  // Clock and reset.
  input wire logic        I_CLOCK,
  input wire logic        I_RST,
  // Register port.
  input wire logic [7:0]  i_ADDR,
  input wire logic [31:0] i_WDATA,
  input wire logic        i_WR,
  input wire logic        i_RD,
  input wire logic [31:0] o_RDATA,
  // Operator, axes and process inputs.
  input wire logic        i_ENABLE,
  input wire logic [3:0]  i_NODE_ID,
  input wire logic [3:0]  i_AXIS_ERR,
  input wire logic [31:0] i_SENSOR_WORD,
  input wire logic [31:0] i_SYNC_DEV,
  // Outputs under watch.
  input wire logic [3:0]  o_AXIS_ENABLE,
  input wire logic        o_READY,
  input wire logic        o_LINK_RETRY,
  input wire logic        o_SENSOR_ERR,
  input wire logic [31:0] o_POSITION
);
  logic [1:0]  mon_reg;
  logic        halt_reg;
  logic [31:0] mask_reg;
  logic [8:0]  sel_reg;
  logic [31:0] win_reg;
  logic [31:0] clr_w;
  logic [31:0] dev_abs_w;

  // Shadow of the settings, so each property knows which mode is in force.
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      mon_reg  <= MON_RST;
      halt_reg <= HALT_RST;
      mask_reg <= MASK_RST;
      sel_reg  <= 9'h000;
      win_reg  <= WINDOW_RST;
    end else if (i_WR) begin
      if (i_ADDR == CTRL_OFS && i_WDATA[1:0] != 2'h3) mon_reg <= i_WDATA[1:0];
      if (i_ADDR == CTRL_OFS) halt_reg <= i_WDATA[HALT_BIT];
      if (i_ADDR == FAULT_MONITOR_SETTING_MASK_OFS) mask_reg <= i_WDATA;
      if (i_ADDR == FAULT_MONITOR_SETTING_ERRBIT_OFS) sel_reg <= i_WDATA[8:0];
      if (i_ADDR == SYNC_WIN_OFS) win_reg <= i_WDATA;
    end
  end

  // Bits kept out of the position, and the deviation magnitude.
  assign clr_w     = mask_reg | (sel_reg[ERRBIT_EN] ? (32'h1 << sel_reg[4:0]) : 32'h0);
  assign dev_abs_w = i_SYNC_DEV[31] ? (32'h0 - i_SYNC_DEV) : i_SYNC_DEV;

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);

  a_rdata_idle_zero: assert property (!i_RD |=> o_RDATA == 32'h0)
    else $error("read data not zero outside a read");
  a_node_id_read: assert property (i_RD && i_ADDR == NODE_ID_OFS |=> o_RDATA == {28'h0, $past(i_NODE_ID)})
    else $error("node id read wrong");
  a_on_err_drop: assert property (mon_reg == MON_ON && o_READY && i_AXIS_ERR[0]
    |=> !o_READY && o_AXIS_ENABLE == 4'h0) else $error("axis error did not drop enables");
  a_off_keeps_ready: assert property (mon_reg == MON_OFF && !halt_reg && o_READY && i_ENABLE && !i_WR
    |=> o_READY) else $error("ready lost with monitoring off");
  a_retry_pulse_gap: assert property (o_LINK_RETRY |-> $past(mon_reg) == MON_OFF ##1 !o_LINK_RETRY [*8])
    else $error("link retry outside off mode or too close");
  a_position_masked: assert property (1'b1 |=> o_POSITION == $past(i_SENSOR_WORD & ~clr_w))
    else $error("position not masked");
  a_sensor_flag_sel: assert property (1'b1 |=> o_SENSOR_ERR == $past(sel_reg[8] & i_SENSOR_WORD[sel_reg[4:0]]))
    else $error("sensor error flag wrong");
  a_sync_halt_drop: assert property (halt_reg && o_READY && dev_abs_w > win_reg |=> !o_READY)
    else $error("sync deviation did not halt");
endmodule // axis_fault_supervisor_monitor

bind axis_fault_supervisor axis_fault_supervisor_monitor #(.POLL_COUNT(POLL_COUNT)) i_monitor (
  .I_CLOCK, .I_RST, .i_ADDR, .i_WDATA, .i_WR, .i_RD, .o_RDATA, .i_ENABLE, .i_NODE_ID, .i_AXIS_ERR,
  .i_SENSOR_WORD, .i_SYNC_DEV, .o_AXIS_ENABLE, .o_READY, .o_LINK_RETRY, .o_SENSOR_ERR, .o_POSITION);

//--- sim/axis_module_model.sv
`timescale 1ns/1ps
module axis_module_model (
  // Clock and reset.
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // Commands from the bench.
  input  wire logic [3:0] i_fail,
  input  wire logic [3:0] i_own_on,
  input  wire logic       i_link,
  input  wire logic [7:0] i_delay,
  // Status as the supervisor receives it.
  output logic      [3:0] o_err,
  output logic      [3:0] o_standby,
  output logic      [3:0] o_fault_monitor_setting_on,
  output logic            o_link_ok
);
  logic [7:0] wait_reg;

  // Reports land after the commanded delay, so a slow bus is modelled too.
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_err     <= 4'h0;
      o_link_ok <= 1'b1;
      wait_reg  <= 8'h00;
    end else if (o_err != i_fail || o_link_ok != i_link) begin
      wait_reg <= wait_reg + 8'h01;
      if (wait_reg >= i_delay) begin
        o_err     <= i_fail;
        o_link_ok <= i_link;
        wait_reg  <= 8'h00;
      end
    end
  end

  // A faulting axis also stands by, the harsher case for the supervisor.
  assign o_standby = o_err;
  assign o_fault_monitor_setting_on = i_own_on;
endmodule // axis_module_model

//--- sim/tb_axis_fault_supervisor.sv
`timescale 1ns/1ps
module tb_axis_fault_supervisor
  import fault_supervisor_pkg::*;
;
  localparam int POLL = 20;
  logic        clk, rst, wr, rd, en, lnk, alink, ready, retry, serr, irq;
  logic [7:0]  addr, dly;
  logic [31:0] wdata, rdata, sword, sdev, pos, got;
  logic [3:0]  nid, fail, own, aerr, astb, ason, aen;
  logic [7:0]  logq[$];
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  axis_fault_supervisor #(.POLL_COUNT(POLL)) i_dut (
    .I_CLOCK(clk), .I_RST(rst), .i_ADDR(addr), .i_WDATA(wdata), .i_WR(wr), .i_RD(rd), .o_RDATA(rdata),
    .i_ENABLE(en), .i_NODE_ID(nid), .i_AXIS_ERR(aerr), .i_AXIS_STANDBY(astb), .i_AXIS_FAULT_MONITOR_SETTING_ON(ason),
    .i_LINK_OK(alink), .i_SENSOR_WORD(sword), .i_SYNC_DEV(sdev), .o_AXIS_ENABLE(aen), .o_READY(ready),
    .o_LINK_RETRY(retry), .o_SENSOR_ERR(serr), .o_POSITION(pos), .o_IRQ(irq));
  axis_module_model i_axes (
    .i_clock(clk), .i_rst(rst), .i_fail(fail), .i_own_on(own), .i_link(lnk), .i_delay(dly),
    .o_err(aerr), .o_standby(astb), .o_fault_monitor_setting_on(ason), .o_link_ok(alink));

  // Free-running clock, 4 ns period.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // A hang ends the run as a failure.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data is only valid in the single cycle after the strobe.
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_ready(input logic v, input int lim);
    int n;
    n = 0;
    // Step off the launching edge so ready is read settled.
    #1;
    while (ready !== v && n < lim) begin
      ticks(1);
      n++;
    end
    chk({31'h0, ready}, {31'h0, v}, "ready level");
  endtask

  task automatic toggle_en();
    @(posedge clk);
    en <= 1'b0;
    @(posedge clk);
    en <= 1'b1;
    ticks(2);
  endtask

  // Expected log keeps only the newest entries.
  task automatic logged(input logic [7:0] c);
    logq.push_back(c);
    if (logq.size() > LOG_DEPTH) logq.pop_front();
  endtask

  task automatic check_log();
    int k;
    wreg(LOG_QUERY_OFS, 32'h0);
    k = LOG_DEPTH - logq.size();
    for (int i = 0; i < LOG_DEPTH; i++) begin
      rreg(LOG_QUERY_OFS);
      chk(got, (i < k) ? {8'h0, LOG_EMPTY} : {24'h0, logq[i - k]}, "log line");
    end
  endtask

  task automatic test_reset();
    rreg(CTRL_OFS);
    chk(got, {21'h0, COUNT_RST, 3'h0, HALT_RST, 2'h0, MON_RST}, "control reset");
    rreg(SYNC_WIN_OFS);
    chk(got, WINDOW_RST, "window default");
    rreg(FAULT_MONITOR_SETTING_MASK_OFS);
    chk(got, MASK_RST, "mask reset");
    rreg(8'h2C);
    chk(got, 32'h0, "unmapped read");
    check_log();
    $display("test_reset done");
  endtask

  task automatic test_node_irq();
    @(posedge clk);
    nid <= 4'hA;
    rreg(NODE_ID_OFS);
    chk(got, 32'hA, "node id");
    wreg(POSITION_OFS, 32'h1234_5678);
    rreg(IRQ_STAT_OFS);
    chk(got, 32'h10, "rejected write flag");
    chk({31'h0, irq}, 32'h0, "irq masked");
    wreg(IRQ_MASK_OFS, 32'h10);
    ticks(2);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wreg(IRQ_STAT_OFS, 32'h10);
    ticks(2);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wreg(IRQ_MASK_OFS, 32'h0);
    $display("test_node_irq done");
  endtask

  task automatic test_sensor();
    wreg(FAULT_MONITOR_SETTING_MASK_OFS, 32'h8000_000F);
    wreg(FAULT_MONITOR_SETTING_ERRBIT_OFS, 32'h0000_0105);
    sword <= 32'hFFFF_FFFF;
    ticks(2);
    chk(pos, 32'h7FFF_FFD0, "masked position");
    chk({31'h0, serr}, 32'h1, "sensor flag set");
    rreg(POSITION_OFS);
    chk(got, 32'h7FFF_FFD0, "position read");
    @(posedge clk);
    sword <= 32'h0000_00DF;
    ticks(2);
    chk(pos, 32'h0000_00D0, "second position");
    chk({31'h0, serr}, 32'h0, "sensor flag clear");
    $display("test_sensor done");
  endtask

  task automatic test_fault_on();
    @(posedge clk);
    en <= 1'b1;
    wait_ready(1'b1, 20);
    chk({28'h0, aen}, 32'h3, "two axes enabled");
    @(posedge clk);
    fail <= 4'h1;
    own <= 4'h1;
    wait_ready(1'b0, 10);
    logged(8'h11);
    chk({28'h0, aen}, 32'h0, "enables withdrawn");
    rreg(IRQ_STAT_OFS);
    chk(got, 32'h3, "shutdown and axis flags");
    wreg(IRQ_STAT_OFS, 32'h3);
    fail <= 4'h0;
    ticks(5);
    chk({31'h0, ready}, 32'h0, "latched until ack");
    toggle_en();
    chk({31'h0, ready}, 32'h0, "ack alone not enough");
    toggle_en();
    wait_ready(1'b1, 5);
    $display("test_fault_on done");
  endtask

  task automatic test_own_off(input logic [3:0] ax, input logic [7:0] d);
    @(posedge clk);
    dly <= d;
    fail <= ax;
    own <= 4'h0;
    wait_ready(1'b0, 20);
    logged({4'h1, (ax == 4'h1) ? 4'h1 : 4'h2});
    fail <= 4'h0;
    wait_ready(1'b1, 20);
    dly <= 8'h00;
  endtask

  task automatic test_auto();
    wreg(CTRL_OFS, 32'h0000_0202);
    fail <= 4'h1;
    own <= 4'h1;
    wait_ready(1'b0, 10);
    logged(8'h11);
    fail <= 4'h0;
    wait_ready(1'b1, POLL + 10);
    wreg(CTRL_OFS, 32'h0000_0201);
    $display("test_auto done");
  endtask

  task automatic test_off();
    int n;
    n = 0;
    wreg(CTRL_OFS, 32'h0000_0200);
    fail <= 4'h3;
    ticks(10);
    chk({31'h0, ready}, 32'h1, "errors ignored");
    lnk <= 1'b0;
    ticks(5);
    repeat (3 * POLL) begin
      ticks(1);
      if (retry === 1'b1) n++;
    end
    chk(n, 3, "retry count");
    rreg(IRQ_STAT_OFS);
    chk(got & 32'h0000_0008, 32'h0000_0008, "retry flag");
    lnk <= 1'b1;
    fail <= 4'h0;
    ticks(3);
    wreg(CTRL_OFS, 32'h0000_0201);
    $display("test_off done");
  endtask

  task automatic test_sync();
    wreg(SYNC_WIN_OFS, 32'd100);
    wreg(CTRL_OFS, 32'h0000_0211);
    sdev <= 32'd100;
    ticks(5);
    chk({31'h0, ready}, 32'h1, "deviation at window");
    rreg(SYNC_DEV_OFS);
    chk(got, 32'h0000_0064, "deviation read");
    @(posedge clk);
    sdev <= 32'hFFFF_FF9B;
    wait_ready(1'b0, 10);
    logged(8'h30);
    rreg(IRQ_STAT_OFS);
    chk(got & 32'h0000_0004, 32'h0000_0004, "sync flag");
    @(posedge clk);
    sdev <= 32'h0;
    toggle_en();
    toggle_en();
    wait_ready(1'b1, 10);
    wreg(CTRL_OFS, 32'h0000_0201);
    check_log();
    $display("test_sync done");
  endtask

  task automatic test_wrap();
    for (int i = 0; i < 8; i++) begin
      test_own_off((i % 2 == 0) ? 4'h1 : 4'h2, 8'h00);
    end
    check_log();
    $display("test_wrap done");
  endtask

  // Axis count four is taken as is and zero is clamped to one; an illegal monitoring code keeps the old one.
  task automatic test_count();
    wreg(CTRL_OFS, 32'h0000_0403);
    rreg(CTRL_OFS);
    chk(got, 32'h0000_0401, "count written, code 3 refused");
    ticks(2);
    chk({28'h0, aen}, 32'h0000_000F, "four axes enabled");
    wreg(CTRL_OFS, 32'h0000_0001);
    ticks(2);
    chk({28'h0, aen}, 32'h0000_0001, "count clamped to one");
    wreg(CTRL_OFS, 32'h0000_0201);
    $display("test_count done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    rst = 1'b1;
    {wr, rd, en, addr, wdata, nid, fail, own, dly, sword, sdev} = '0;
    lnk = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_node_irq();
    test_sensor();
    test_fault_on();
    test_count();
    test_own_off(4'h2, 8'h06);
    $display("test_own_off done");
    test_auto();
    test_off();
    test_sync();
    test_wrap();
    complete_run();
  end
endmodule // tb_axis_fault_supervisor
